//--- rtl/smart_wv.sv
/*
 * Task-file command interpreter: sector write, verified write and
 * the SMART command family, reached over classic Wishbone.
 * Assumes a media engine that answers each go pulse with done, and
 * that extended SMART values arrive on the clk_i domain.
 */
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "smart_wv_cfg.svh"
module smart_wv
    import smart_wv_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic intrq_o,
    output media_req_s media_o,
    output logic [7:0] media_wdata_o,
    output logic media_wstb_o,
    input wire logic media_done_i,
    input wire logic media_err_i,
    input wire spare_s [`N_CHIP-1:0] spare_i,
    input wire smart_ext_s ext_i,
    output logic [8:0] ext_idx_o,
    input wire logic [7:0] ext_byte_i,
    input wire logic nv_en_i,
    output logic nv_wr_o,
    output logic smart_en_o
);

state_e st_r;
logic ack_r;
logic [31:0] dat_r;
logic [7:0] feat_r, cnt_r, lba0_r, lba1_r, lba2_r, dev_r, err_r;
logic bsy_r, drq_r, errst_r, intrq_r, vfy_r, thr_r;
logic [8:0] idx_r;
logic [7:0] sum_r, worst_r, wdat_r;
logic wstb_r, en_r, nvld_r, nvwr_r;
media_req_s med_r;
logic acc, wr, rd, cmd_go, wcmd, sig_ok, feat_ok, run_ok, abort;
logic rdsec, exceed, done_ok, adv, last, d_wr, d_rd;
logic [7:0] sb, rb, stat, pct_min;
logic [3:0] rel;
logic [23:0] ini_sum, cur_sum;
logic [22:0] prod, q;
logic [27:0] lba_nxt;

// ----------------------------------------
// byte lane helper
// ----------------------------------------
// picks byte d of v, lowest byte first
function automatic logic [7:0] le32(input logic [31:0] v,
                                    input logic [8:0] d);
    le32 = v[{d[1:0], 3'b000} +: 8]; // [RULE15]
endfunction

// ----------------------------------------
// wishbone slave
// ----------------------------------------
always_ff @(posedge clk_i)
begin
    if (rst_i)
        ack_r <= 1'b0;
    else
        ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
end

// read data registered on the same edge that raises ack
always_ff @(posedge clk_i)
begin
    if (rst_i)
        dat_r <= 32'h00000000;
    else if (wb_cyc_i & wb_stb_i & ~ack_r)
        dat_r <= {24'h000000, rb};
end

assign wb_ack_o = ack_r;
assign wb_dat_o = dat_r;
assign acc = wb_cyc_i & wb_stb_i & ack_r;
assign wr = acc & wb_we_i & wb_sel_i[0];
assign rd = acc & ~wb_we_i;
assign d_wr = wr & (wb_adr_i == `A_DATA) & (st_r == ST_IN);
assign d_rd = rd & (wb_adr_i == `A_DATA) & (st_r == ST_OUT);
assign last = idx_r == `SECT_LAST;

always_comb
begin
    stat = 8'h00;
    stat[`ST_BSY] = bsy_r;
    stat[`ST_RDY] = ~bsy_r;
    stat[`ST_DSC] = ~bsy_r;
    stat[`ST_DRQ] = drq_r;
    stat[`ST_ERR] = errst_r;
end

always_comb
begin
    case (wb_adr_i)
        `A_DATA: rb = (st_r == ST_OUT) ? sb : 8'h00;
        `A_ERRFT: rb = err_r;
        `A_SECCNT: rb = cnt_r;
        `A_LBA0: rb = lba0_r;
        `A_LBA1: rb = lba1_r;
        `A_LBA2: rb = lba2_r;
        `A_DEVHD: rb = dev_r;
        `A_STCMD: rb = stat;
        default: rb = 8'h00;
    endcase
end

// ----------------------------------------
// command decode
// ----------------------------------------
assign cmd_go = wr & (wb_adr_i == `A_STCMD) & (st_r == ST_IDLE);
// both write codes take the same sector path [RULE2]
assign wcmd = (wb_dat_i[7:0] == `C_WRITE) | (wb_dat_i[7:0] == `C_WRVFY);
assign sig_ok = (wb_dat_i[7:0] == `C_SMART) & (lba2_r == `SIG_HI)
    & (lba1_r == `SIG_LO); // [RULE22]
assign feat_ok = (feat_r == `F_RDATA) | (feat_r == `F_RTHR)
    | (feat_r == `F_AUTOS) | (feat_r == `F_EN) | (feat_r == `F_DIS)
    | (feat_r == `F_STAT); // [RULE6]
assign run_ok = sig_ok & feat_ok & (en_r | (feat_r == `F_EN));
assign abort = ~wcmd & ~run_ok; // [RULE7]
assign rdsec = (feat_r == `F_RDATA) | (feat_r == `F_RTHR);
assign exceed = pct_min < `SPARE_THR; // [RULE21]
assign done_ok = media_done_i & ~media_err_i;
assign adv = (((st_r == ST_WR) & ~vfy_r) | (st_r == ST_VFY)) & done_ok;
assign lba_nxt = {dev_r[3:0], lba2_r, lba1_r, lba0_r} + `LBA_ONE;

// ----------------------------------------
// task file
// ----------------------------------------
always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        feat_r <= 8'h00;
        cnt_r <= 8'h00;
        lba0_r <= 8'h00;
        lba1_r <= 8'h00;
        lba2_r <= 8'h00;
        dev_r <= 8'h00;
    end
    else if (wr & (st_r == ST_IDLE))
    begin
        case (wb_adr_i)
            `A_ERRFT: feat_r <= wb_dat_i[7:0];
            `A_SECCNT: cnt_r <= wb_dat_i[7:0];
            `A_LBA0: lba0_r <= wb_dat_i[7:0];
            `A_LBA1: lba1_r <= wb_dat_i[7:0];
            `A_LBA2: lba2_r <= wb_dat_i[7:0];
            `A_DEVHD: dev_r <= wb_dat_i[7:0];
            `A_STCMD:
            begin
                if (run_ok & (feat_r == `F_STAT))
                begin
                    // [RULE24]
                    lba2_r <= exceed ? `SIG_XHI : `SIG_HI;
                    lba1_r <= exceed ? `SIG_XLO : `SIG_LO;
                end
            end
            default: ;
        endcase
    end
    else if (adv)
    begin
        // failing sector never advances the address [RULE5]
        {dev_r[3:0], lba2_r, lba1_r, lba0_r} <= lba_nxt;
        cnt_r <= cnt_r - `CNT_ONE; // zero wraps, giving 256 [RULE3]
    end
end

// ----------------------------------------
// command sequencer
// ----------------------------------------
always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        st_r <= ST_IDLE;
        bsy_r <= 1'b0;
        drq_r <= 1'b0;
        errst_r <= 1'b0;
        err_r <= 8'h00;
        intrq_r <= 1'b0;
        vfy_r <= 1'b0;
        thr_r <= 1'b0;
        idx_r <= 9'h000;
        sum_r <= 8'h00;
        med_r <= '0;
        wdat_r <= 8'h00;
        wstb_r <= 1'b0;
    end
    else
    begin
        wstb_r <= 1'b0;
        med_r.go <= 1'b0;
        if ((rd & (wb_adr_i == `A_STCMD)) | cmd_go)
            intrq_r <= 1'b0;
        case (st_r)
            ST_IDLE:
            begin
                if (cmd_go)
                begin
                    errst_r <= abort;
                    err_r <= 8'h00;
                    err_r[`ER_ABRT] <= abort;
                    if (wcmd)
                    begin
                        st_r <= ST_ACC; // [RULE4]
                        bsy_r <= 1'b1;
                        vfy_r <= wb_dat_i[7:0] == `C_WRVFY;
                        idx_r <= 9'h000;
                    end
                    else if (~abort & rdsec)
                    begin
                        st_r <= ST_OUT;
                        drq_r <= 1'b1;
                        thr_r <= feat_r == `F_RTHR;
                        idx_r <= 9'h000;
                        sum_r <= 8'h00;
                        intrq_r <= 1'b1;
                    end
                    else
                        intrq_r <= 1'b1; // [RULE9]
                end
            end
            ST_ACC:
            begin
                st_r <= ST_IN;
                bsy_r <= 1'b0;
                drq_r <= 1'b1;
            end
            ST_IN:
            begin
                if (d_wr)
                begin
                    wdat_r <= wb_dat_i[7:0];
                    wstb_r <= 1'b1;
                    idx_r <= idx_r + 9'h001;
                    if (last)
                    begin
                        st_r <= ST_WR;
                        drq_r <= 1'b0;
                        bsy_r <= 1'b1;
                        med_r.go <= 1'b1;
                        med_r.vfy <= 1'b0;
                        med_r.lba <= {dev_r[3:0], lba2_r, lba1_r, lba0_r};
                    end
                end
            end
            ST_WR, ST_VFY:
            begin
                if (media_done_i & media_err_i)
                begin
                    st_r <= ST_IDLE;
                    bsy_r <= 1'b0;
                    errst_r <= 1'b1;
                    err_r[`ER_MEDIA] <= 1'b1;
                    intrq_r <= 1'b1;
                end
                else if (done_ok & vfy_r & (st_r == ST_WR))
                begin
                    st_r <= ST_VFY; // [RULE1]
                    med_r.go <= 1'b1;
                    med_r.vfy <= 1'b1;
                end
                else if (adv)
                begin
                    bsy_r <= 1'b0;
                    intrq_r <= 1'b1;
                    idx_r <= 9'h000;
                    if (cnt_r == `CNT_ONE)
                        st_r <= ST_IDLE;
                    else
                    begin
                        st_r <= ST_IN; // [RULE4]
                        drq_r <= 1'b1;
                    end
                end
            end
            ST_OUT:
            begin
                if (d_rd)
                begin
                    idx_r <= idx_r + 9'h001;
                    sum_r <= sum_r + dat_r[7:0];
                    if (last)
                    begin
                        st_r <= ST_IDLE; // [RULE10]
                        drq_r <= 1'b0;
                    end
                end
            end
            default: st_r <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------
// smart enable, nonvolatile copy
// ----------------------------------------
always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        en_r <= 1'b0;
        nvld_r <= 1'b0;
        nvwr_r <= 1'b0;
    end
    else
    begin
        nvwr_r <= 1'b0;
        if (~nvld_r)
        begin
            en_r <= nv_en_i;
            nvld_r <= 1'b1;
        end
        else if (cmd_go & run_ok & (feat_r == `F_EN))
        begin
            en_r <= 1'b1; // [RULE8]
            nvwr_r <= 1'b1;
        end
        else if (cmd_go & run_ok & (feat_r == `F_DIS))
        begin
            en_r <= 1'b0; // [RULE8]
            nvwr_r <= 1'b1;
        end
    end
end

// ----------------------------------------
// spare block attribute
// ----------------------------------------
always_comb
begin
    pct_min = `PCT_FULL;
    ini_sum = 24'h000000;
    cur_sum = 24'h000000;
    prod = 23'h000000;
    q = 23'h000000;
    for (int i = 0; i < `N_CHIP; i++)
    begin
        prod = 23'(spare_i[i].cur) * 23'(`PCT_FULL);
        q = (spare_i[i].init == 16'h0000) ? 23'(`PCT_FULL)
            : prod / 23'(spare_i[i].init);
        if (q < 23'(pct_min))
            pct_min = 8'(q); // [RULE19]
        ini_sum = ini_sum + 24'(spare_i[i].init); // [RULE20]
        cur_sum = cur_sum + 24'(spare_i[i].cur);
    end
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
        worst_r <= `PCT_FULL;
    else if (pct_min < worst_r)
        worst_r <= pct_min;
end

// ----------------------------------------
// smart sector byte generator
// ----------------------------------------
always_comb
begin
    rel = 4'(idx_r - `O_S0);
    sb = 8'h00;
    if (last)
        sb = 8'h00 - sum_r; // [RULE23]
    else if (idx_r < `O_S0)
        sb = le32({16'h0000, `VER_SMART}, idx_r); // [RULE10]
    else if (thr_r)
    begin
        if ((idx_r < `O_SLOT1) & (rel == `S_ID))
            sb = `ATTR_SPARE;
        else if ((idx_r < `O_SLOT1) & (rel == `S_THR))
            sb = `SPARE_THR;
    end
    else if (idx_r < `O_SLOT1)
    begin
        // [RULE18]
        if (rel == `S_ID)
            sb = `ATTR_SPARE;
        else if (rel < `S_CUR)
            sb = le32({16'h0000, `ATTR_FLAGS}, 9'(rel - `S_FLG));
        else if (rel == `S_CUR)
            sb = pct_min;
        else if (rel == `S_WST)
            sb = worst_r;
        else if (rel < `S_NOW)
            sb = le32({8'h00, ini_sum}, 9'(rel - `S_INI)); // [RULE20]
        else if (rel < `S_RSV)
            sb = le32({8'h00, cur_sum}, 9'(rel - `S_NOW));
    end
    else if (idx_r < `O_EOS)
        sb = ext_byte_i; // [RULE11]
    else if (idx_r < `O_CAP)
        sb = 8'h00;
    else if (idx_r < `O_CAP2)
        sb = le32({16'h0000, `SMART_CAP}, 9'(idx_r - `O_CAP)); // [RULE12]
    else if (idx_r < `O_EXTVER)
        sb = 8'h00;
    else if (idx_r < `O_COMMIT)
        sb = le32({16'h0000, `VER_EXT}, 9'(idx_r - `O_EXTVER)); // [RULE13]
    else if (idx_r < `O_WLTHR)
        sb = le32(ext_i.commit, 9'(idx_r - `O_COMMIT)); // [RULE14]
    else if (idx_r < `O_GBB)
        sb = le32(ext_i.wl_thr, 9'(idx_r - `O_WLTHR));
    else if (idx_r == `O_GBB)
        sb = {7'h00, ext_i.gbb}; // [RULE16]
    else if (idx_r == `O_GWL)
        sb = {7'h00, ext_i.gwl}; // [RULE17]
    else if (idx_r < `O_WLBLK)
        sb = le32(ext_i.avg_erase, 9'(idx_r - `O_AVG));
    else if (idx_r < `O_ECCT)
        sb = le32(ext_i.wl_blocks, 9'(idx_r - `O_WLBLK));
    else if (idx_r < `O_ECCC)
        sb = le32(ext_i.ecc_tot, 9'(idx_r - `O_ECCT));
    else if (idx_r < `O_EXTEND)
        sb = le32(ext_i.ecc_corr, 9'(idx_r - `O_ECCC));
end

assign intrq_o = intrq_r;
assign media_o = med_r;
assign media_wdata_o = wdat_r;
assign media_wstb_o = wstb_r;
assign ext_idx_o = idx_r;
assign nv_wr_o = nvwr_r;
assign smart_en_o = en_r;

// ----------------------------------------
// assertions
// ----------------------------------------
default clocking dc @(posedge clk_i);
endclocking
default disable iff (rst_i);

sequence acc_busy_s;
    bsy_r & ~drq_r;
endsequence
sequence first_drq_s;
    drq_r & ~bsy_r & ~intrq_r;
endsequence

first_drq_a: // [RULE4]
assert property (cmd_go & wcmd |=> acc_busy_s ##1 first_drq_s)
    else $error("first sector handshake wrong");
next_drq_a: // [RULE4]
assert property (adv & (cnt_r != `CNT_ONE) |=> drq_r & intrq_r & ~bsy_r)
    else $error("later sector lacks drq with interrupt");
verify_follow_a: // [RULE1]
assert property ((st_r == ST_WR) & done_ok & vfy_r
    |=> media_o.go & media_o.vfy ##1 ~media_o.go)
    else $error("verify pass not issued after write");
plain_novfy_a: // [RULE2]
assert property ((st_r == ST_WR) & done_ok & ~vfy_r |=> ~media_o.go)
    else $error("plain write issued a verify");
err_stop_a: // [RULE5]
assert property (bsy_r & media_done_i & media_err_i
    |=> (st_r == ST_IDLE) & errst_r & $stable(lba0_r) & $stable(cnt_r))
    else $error("error did not stop at failing sector");
bad_feat_a: // [RULE7]
assert property (cmd_go & sig_ok & ~feat_ok
    |=> errst_r & err_r[`ER_ABRT] & (st_r == ST_IDLE))
    else $error("unsupported feature not aborted");
enable_store_a: // [RULE8]
assert property (cmd_go & run_ok & (feat_r == `F_EN)
    |=> smart_en_o & nv_wr_o ##1 ~nv_wr_o)
    else $error("enable not stored");
autosave_nop_a: // [RULE9]
assert property (cmd_go & run_ok & (feat_r == `F_AUTOS)
    |=> (st_r == ST_IDLE) & ~errst_r & $stable(en_r))
    else $error("autosave had an effect");
sector_end_a: // [RULE10]
assert property (d_rd & last |=> (st_r == ST_IDLE) & ~drq_r)
    else $error("smart sector length wrong");
checksum_a: // [RULE23]
assert property (d_rd & last |-> (8'(sum_r + dat_r[7:0]) == 8'h00))
    else $error("sector checksum wrong");
status_sig_a: // [RULE24]
assert property (cmd_go & run_ok & (feat_r == `F_STAT) & exceed
    |=> (lba2_r == `SIG_XHI) & (lba1_r == `SIG_XLO))
    else $error("exceeded signature wrong");
count_step_a: // [RULE3]
assert property (adv |=> cnt_r == 8'($past(cnt_r) - `CNT_ONE))
    else $error("sector count not stepped");

endmodule
`default_nettype wire

//--- rtl/smart_wv_cfg.svh
/*
 * Constants for the SMART and verified-write command interpreter.
 * Assumes a 20 MHz clock and a classic Wishbone master.
 */
// Functional notes
// RULE1: command 3Ch writes, then verifies each sector
// RULE2: verified write shares plain write protocol
// RULE3: count 1..255 sectors, zero means 256
// RULE4: BSY then DRQ; later sectors interrupt
// RULE5: error stops at failing sector address
// RULE6: features register selects SMART subcommand
// RULE7: unsupported features value is aborted
// RULE8: enable/disable state kept in nonvolatile store
// RULE9: autosave completes with no effect
// RULE10: read data returns one 512-byte sector
// RULE11: thirty 12-byte slots, twelve attributes used
// RULE12: bytes 362..385 zero except capabilities 0003h
// RULE13: bytes 386..387 hold extended version 0004h
// RULE14: bytes 388..413 extended fields, then zero
// RULE15: multi-byte values least significant first
// RULE16: byte 396 flags global bad-block handling
// RULE17: byte 397 flags global wear leveling
// RULE18: slot layout; spare slot c4h, flags 0003h
// RULE19: spare value is minimum per-chip percentage
// RULE20: spare slot carries initial and current sums
// RULE21: status exceeded when spare below threshold
// RULE22: SMART needs B0h and C2h/4Fh signature
// RULE23: last byte makes sector sum zero
// RULE24: status answers C2h/4Fh or 2Ch/F4h
`ifndef SMART_WV_CFG_SVH
`define SMART_WV_CFG_SVH
`define A_DATA 8'h00
`define A_ERRFT 8'h04
`define A_SECCNT 8'h08
`define A_LBA0 8'h0C
`define A_LBA1 8'h10
`define A_LBA2 8'h14
`define A_DEVHD 8'h18
`define A_STCMD 8'h1C
`define C_WRITE 8'h30
`define C_WRVFY 8'h3C
`define C_SMART 8'hB0
`define F_RDATA 8'hD0
`define F_RTHR 8'hD1
`define F_AUTOS 8'hD2
`define F_EN 8'hD8
`define F_DIS 8'hD9
`define F_STAT 8'hDA
`define SIG_HI 8'hC2
`define SIG_LO 8'h4F
`define SIG_XHI 8'h2C
`define SIG_XLO 8'hF4
`define CNT_ONE 8'h01
`define LBA_ONE 28'h0000001
`define VER_SMART 16'h0010
`define VER_EXT 16'h0004
`define SMART_CAP 16'h0003
`define ATTR_SPARE 8'hC4
`define ATTR_FLAGS 16'h0003
`define PCT_FULL 8'h64
`define SPARE_THR 8'h0A
`define N_CHIP 4
`define ST_BSY 7
`define ST_RDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define ER_ABRT 2
`define ER_MEDIA 6
`define S_ID 4'h0
`define S_FLG 4'h1
`define S_THR 4'h1
`define S_CUR 4'h3
`define S_WST 4'h4
`define S_INI 4'h5
`define S_NOW 4'h8
`define S_RSV 4'hB
`define O_S0 9'h002
`define O_SLOT1 9'h00E
`define O_EOS 9'h16A
`define O_CAP 9'h170
`define O_CAP2 9'h172
`define O_EXTVER 9'h182
`define O_COMMIT 9'h184
`define O_WLTHR 9'h188
`define O_GBB 9'h18C
`define O_GWL 9'h18D
`define O_AVG 9'h18E
`define O_WLBLK 9'h192
`define O_ECCT 9'h196
`define O_ECCC 9'h19A
`define O_EXTEND 9'h19E
`define SECT_LAST 9'h1FF
`endif

//--- rtl/smart_wv_pkg.sv
/*
 * Types for the SMART and verified-write command interpreter.
 * Assumes smart_wv_cfg.svh supplies all numeric constants.
 */
package smart_wv_pkg;
    typedef struct packed {
        logic go;
        logic vfy;
        logic [27:0] lba;
    } media_req_s;
    typedef struct packed {
        logic [15:0] cur;
        logic [15:0] init;
    } spare_s;
    typedef struct packed {
        logic [31:0] commit;
        logic [31:0] wl_thr;
        logic gbb;
        logic gwl;
        logic [31:0] avg_erase;
        logic [31:0] wl_blocks;
        logic [31:0] ecc_tot;
        logic [31:0] ecc_corr;
    } smart_ext_s;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ACC = 3'h1,
        ST_IN = 3'h3,
        ST_WR = 3'h2,
        ST_VFY = 3'h6,
        ST_OUT = 3'h4
    } state_e;
endpackage

//--- testbench/media_model.sv
/*
 * Media engine stand-in: answers every go with a done pulse, except when lag_i is zero.
 * Assumes the interpreter's clock and synchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
module media_model
    import smart_wv_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire media_req_s media_i,
    input wire logic [27:0] bad_lba_i,
    input wire logic [7:0] lag_i,
    output logic done_o,
    output logic err_o
);
// ----
// delayed answer, error only where asked
// ----
logic [7:0] cnt_r;
logic bad_r;
always_ff @(posedge clk_i)
begin
    done_o <= 1'b0;
    err_o <= 1'b0;
    if (rst_i)
    begin
        cnt_r <= 8'h00;
        bad_r <= 1'b0;
    end
    else if (media_i.go)
    begin
        cnt_r <= lag_i;
        bad_r <= media_i.lba == bad_lba_i;
    end
    else if (cnt_r == 8'h01)
    begin
        cnt_r <= 8'h00;
        done_o <= 1'b1;
        err_o <= bad_r;
    end
    else if (cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01;
end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
/*
 * Self-checking bench for the interpreter.
 * Assumes smart_wv, media_model and the shared constants header.
 */
`timescale 1ns/100ps
`default_nettype none
`include "smart_wv_cfg.svh"
module testbench
    import smart_wv_pkg::*;
;
logic clk_i;
logic rst_i = 1'b1;
logic cyc = 1'b0, stb = 1'b0, we = 1'b0, rd_chk = 1'b0, nv_en = 1'b0;
logic [7:0] adr = 8'h00, wdat, ext_byte, lag = 8'h01;
logic [31:0] dat = 32'h0, rdat;
logic ack, intrq, wstb, done, err, nv_wr, smart_en, nv_p = 1'b0;
media_req_s media;
spare_s [`N_CHIP-1:0] spare = {`N_CHIP{32'h00400040}};
smart_ext_s ext = '0;
logic [8:0] ext_idx;
logic [27:0] bad_lba = 28'hFFFFFFF;
logic [7:0] ex[512];
logic [7:0] exp_rd[$], exp_wr[$];
logic [28:0] exp_go[$];
int mismatches = 0, tests_run = 0, nv_cnt = 0;
assign ext_byte = ext_idx[7:0] ^ 8'hA5;
smart_wv smart_wv_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .intrq_o(intrq),
    .media_o(media), .media_wdata_o(wdat), .media_wstb_o(wstb),
    .media_done_i(done), .media_err_i(err), .spare_i(spare), .ext_i(ext),
    .ext_idx_o(ext_idx), .ext_byte_i(ext_byte), .nv_en_i(nv_en),
    .nv_wr_o(nv_wr), .smart_en_o(smart_en));
media_model media_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .media_i(media), .bad_lba_i(bad_lba), .lag_i(lag), .done_o(done),
    .err_o(err));
initial
begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
end
// ----
// compares and result monitor
// ----
task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
        mismatches++;
        $display("unexpected byte at %0t: got %h exp %h", $time, g, e);
    end
endtask
task automatic cmp_go(input logic [28:0] g, input logic [28:0] e);
    tests_run++;
    if (g !== e)
    begin
        mismatches++;
        $display("unexpected go at %0t: got %h exp %h", $time, g, e);
    end
endtask
always @(posedge clk_i)
begin
    nv_p <= nv_wr;
    if (nv_p === 1'b1)
    begin
        nv_cnt++;
        nv_en <= smart_en;
    end
    if (ack === 1'b1 && rd_chk === 1'b1)
        cmp_byte(rdat[7:0], exp_rd.pop_front());
    if (wstb === 1'b1)
        cmp_byte(wdat, exp_wr.pop_front());
    if (media.go === 1'b1)
        cmp_go({media.vfy, media.lba}, exp_go.pop_front());
end
task automatic finish_test();
    if (exp_rd.size() + exp_wr.size() + exp_go.size() != 0)
        mismatches++;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0)
        $display("== PASSED ==");
    else
        $display("== FAILED ==");
    $finish;
endtask
initial
begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    finish_test();
end
// ----
// bus and command tasks
// ----
task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                  input logic c, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    rd_chk <= c;
    do
    begin
        @(posedge clk_i);
        n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
        mismatches++;
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    rd_chk <= 1'b0;
endtask
task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    exp_rd.push_back(e);
    wb(1'b0, a, 8'h00, 1'b1, q);
endtask
task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
    logic [7:0] q;
    int n;
    n = 0;
    do
    begin
        wb(1'b0, `A_STCMD, 8'h00, 1'b0, q);
        n++;
    end
    while ((q & m) !== v && n < 500);
    if (n >= 500)
        mismatches++;
endtask
task automatic cmd(input logic [7:0] c, input logic [7:0] f,
                   input logic [7:0] n, input logic [27:0] l);
    logic [7:0] q;
    wb(1'b1, `A_ERRFT, f, 1'b0, q);
    wb(1'b1, `A_SECCNT, n, 1'b0, q);
    wb(1'b1, `A_LBA0, l[7:0], 1'b0, q);
    wb(1'b1, `A_LBA1, l[15:8], 1'b0, q);
    wb(1'b1, `A_LBA2, l[23:16], 1'b0, q);
    wb(1'b1, `A_DEVHD, {4'hE, l[27:24]}, 1'b0, q);
    wb(1'b1, `A_STCMD, c, 1'b0, q);
    wait_st(8'h80, 8'h00);
endtask
task automatic sm(input logic [7:0] f, input logic [7:0] n);
    cmd(`C_SMART, f, n, {4'h0, `SIG_HI, `SIG_LO, 8'h00});
endtask
task automatic sect(input logic [27:0] l, input logic v);
    logic [7:0] b, q;
    wait_st(8'h88, 8'h08);
    exp_go.push_back({1'b0, l});
    if (v)
        exp_go.push_back({1'b1, l});
    repeat (512)
    begin
        b = 8'($urandom);
        exp_wr.push_back(b);
        wb(1'b1, `A_DATA, b, 1'b0, q);
    end
endtask
task automatic build(input logic t);
    int p, s, k;
    logic [23:0] si, sc;
    logic [31:0] wv[6];
    int off[6];
    p = 100;
    si = 24'h0;
    sc = 24'h0;
    ex = '{default: 8'h00};
    for (k = 0; k < `N_CHIP; k++)
    begin
        s = (spare[k].init == 0) ? 100 : 100 * spare[k].cur / spare[k].init;
        p = (s < p) ? s : p;
        si += 24'(spare[k].init);
        sc += 24'(spare[k].cur);
    end
    ex[0] = 8'h10;
    ex[2] = 8'hC4;
    ex[3] = t ? `SPARE_THR : 8'h03;
    if (!t)
    begin
        ex[5] = 8'(p);
        ex[6] = 8'(p);
        {ex[9], ex[8], ex[7]} = si;
        {ex[12], ex[11], ex[10]} = sc;
        for (k = 14; k < 362; k++)
            ex[k] = 8'(k) ^ 8'hA5;
        ex[368] = 8'h03;
        ex[386] = 8'h04;
        ex[396] = {7'h0, ext.gbb};
        ex[397] = {7'h0, ext.gwl};
        wv = '{ext.commit, ext.wl_thr, ext.avg_erase, ext.wl_blocks,
               ext.ecc_tot, ext.ecc_corr};
        off = '{388, 392, 398, 402, 406, 410};
        for (k = 0; k < 6; k++)
            {ex[off[k]+3], ex[off[k]+2], ex[off[k]+1], ex[off[k]]} = wv[k];
    end
    s = 0;
    for (k = 0; k < 511; k++)
        s += ex[k];
    ex[511] = 8'(-s);
endtask
// ----
// main sequence
// ----
initial
begin
    int i;
    logic [7:0] f, ini, q;
    logic [27:0] l;
    void'($urandom(32'hFD565A02));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(`A_STCMD, 8'h50);
    rc(8'h20, 8'h00);
    sm(`F_RDATA, 8'h00);
    rc(`A_ERRFT, 8'h04);
    sm(`F_EN, 8'h00);
    cmp_byte({7'h0, smart_en}, 8'h01);
    for (i = 0; i < 4; i++)
    begin
        f = 8'($urandom);
        if (f inside {8'hD0, 8'hD1, 8'hD2, 8'hD8, 8'hD9, 8'hDA})
            f = 8'hDB;
        sm(f, 8'h00);
        rc(`A_ERRFT, 8'h04);
    end
    cmd(`C_SMART, `F_AUTOS, 8'h00, {4'h0, `SIG_HI, 8'h4E, 8'h00});
    rc(`A_ERRFT, 8'h04);
    sm(`F_AUTOS, 8'h00);
    rc(`A_STCMD, 8'h50);
    sm(`F_AUTOS, 8'hF1);
    rc(`A_STCMD, 8'h50);
    wb(1'b1, `A_STCMD, `C_SMART, 1'b0, q);
    @(posedge clk_i);
    cmp_byte({7'h0, intrq}, 8'h01);
    sm(`F_STAT, 8'h00);
    rc(`A_LBA2, 8'hC2);
    ext <= {$urandom, $urandom, 2'($urandom), $urandom, $urandom,
            $urandom, $urandom};
    for (i = 0; i < `N_CHIP; i++)
    begin
        ini = 8'($urandom_range(200, 50));
        spare[i] <= {8'h00, 8'($urandom_range(ini, 0)), 8'h00, ini};
    end
    sm(`F_RDATA, 8'h00);
    build(1'b0);
    for (i = 0; i < 512; i++)
        rc(`A_DATA, ex[i]);
    rc(`A_STCMD, 8'h50);
    sm(`F_RTHR, 8'h00);
    build(1'b1);
    for (i = 0; i < 512; i++)
        rc(`A_DATA, ex[i]);
    spare[0] <= {16'h0001, 16'h0028};
    sm(`F_STAT, 8'h00);
    rc(`A_LBA2, 8'h2C);
    rc(`A_LBA1, 8'hF4);
    l = 28'($urandom) & 28'hFFFFFF0;
    lag <= 8'($urandom_range(20, 1));
    cmd(`C_WRVFY, 8'h00, 8'h02, l);
    sect(l, 1'b1);
    sect(l + 28'h1, 1'b1);
    wait_st(8'h88, 8'h00);
    rc(`A_STCMD, 8'h50);
    rc(`A_LBA0, l[7:0] + 8'h02);
    rc(`A_SECCNT, 8'h00);
    bad_lba <= l + 28'h1;
    cmd(`C_WRITE, 8'h00, 8'h03, l);
    sect(l, 1'b0);
    sect(l + 28'h1, 1'b0);
    wait_st(8'h88, 8'h00);
    rc(`A_STCMD, 8'h51);
    rc(`A_ERRFT, 8'h40);
    rc(`A_LBA0, l[7:0] + 8'h01);
    rc(`A_SECCNT, 8'h02);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    cmp_byte({7'h0, smart_en}, 8'h01);
    sm(`F_DIS, 8'h00);
    repeat (2) @(posedge clk_i);
    cmp_byte({6'h0, smart_en, nv_en}, 8'h00);
    cmp_byte(8'(nv_cnt), 8'h02);
    finish_test();
end
endmodule
`default_nettype wire
